//--- verilog/rlp_ctrl.sv
// Purpose: Reset, idle/power-down and code-protection control
// Assumes: Core gives a write strobe for the power control register
// Notes:   Oscillator stop and core halt are enables; gating is outside
`timescale 1ns/1ps
module rlp_ctrl (
  input  wire logic       clk,
  input  wire logic       nrst,
  input  wire logic       oscillator_input,
  input  wire logic       reset_pin,
  input  wire logic       external_access_select,
  input  wire logic       security_bit,
  input  wire logic       pwr_wr,
  input  wire logic [7:0] pwr_wdata,
  input  wire logic       instr_done,
  input  wire logic       irq_pending,
  input  wire logic       ale_run,
  input  wire logic       prog_strobe_run,
  input  wire logic       code_read_instr,
  input  wire logic       fetch_internal,
  input  wire logic       fetch_external,
  input  wire logic       test_mode,
  output logic            osc_tick,
  output logic            core_reset,
  output logic            core_run,
  output logic            periph_run,
  output logic            osc_enable,
  output logic            ram_retain,
  output logic            sfr_retain,
  output logic [7:0]      power_control_register,
  output logic            address_latch_strobe,
  output logic            program_store_strobe,
  output logic            port0_oe_block,
  output logic            port2_addr_sel,
  output logic            ext_mem_mode,
  output logic            code_read_grant,
  output logic            irom_read_en
);
  logic [2:0]                       pin_s;
  logic                             access_s;
  logic                             osc_s;
  logic                             rst_s;
  logic                             osc_prev_ff;
  logic                             div_ff;
  logic [rlp_pkg::RST_CNT_W-1:0]    rst_cnt_ff;
  logic                             rst_hit;
  logic                             locked_access_ff;
  rlp_pkg::rlp_mode_e               mode_ff;
  rlp_pkg::rlp_mode_e               nxt_mode;

  // Pins cross into clk before anything looks at them
  // Reset pin stage starts high so no false run follows nrst
  rlp_sync #(.W(3), .RST_VAL(rlp_pkg::PIN_SYNC_RST)) u_sync (
    .clk  (clk),
    .nrst (nrst),
    .d    ({external_access_select, oscillator_input, reset_pin}),
    .q    (pin_s)
  );
  assign access_s = pin_s[2];
  assign osc_s    = pin_s[1];
  assign rst_s    = pin_s[0];

  // Divide-by-two: duty cycle of the oscillator is irrelevant
  always_ff @(posedge clk) begin
    if (!nrst) begin
      osc_prev_ff <= 1'b0;
      div_ff      <= 1'b0;
      osc_tick    <= 1'b0;
    end else begin
      osc_prev_ff <= osc_s;
      osc_tick    <= 1'b0;
      if (osc_s && !osc_prev_ff) begin
        div_ff   <= ~div_ff;
        osc_tick <= div_ff;
      end
    end
  end

  // Count divided ticks with the reset pin high; only a running oscillator counts
  always_ff @(posedge clk) begin
    if (!nrst) begin
      rst_cnt_ff <= '0;
    end else if (!rst_s) begin
      rst_cnt_ff <= '0;
    end else if (osc_tick && !rst_hit) begin
      rst_cnt_ff <= rst_cnt_ff + 1'b1;
    end
  end
  assign rst_hit = rst_cnt_ff >= rlp_pkg::RST_CNT_W'(rlp_pkg::RST_HALF_TICKS);

  // Mode sequencing
  always_comb begin
    nxt_mode = mode_ff;
    unique case (mode_ff)
      rlp_pkg::RLP_RESET: begin
        if (!rst_s) begin
          nxt_mode = rlp_pkg::RLP_RUN;
        end
      end
      rlp_pkg::RLP_RUN: begin
        // Request takes effect only after the requesting instruction ends
        if (instr_done && power_control_register[rlp_pkg::PWR_DOWN_BIT]) begin
          nxt_mode = rlp_pkg::RLP_PDOWN;
        end else if (instr_done && power_control_register[rlp_pkg::PWR_IDLE_BIT]) begin
          nxt_mode = rlp_pkg::RLP_IDLE;
        end
      end
      rlp_pkg::RLP_IDLE: begin
        if (irq_pending) begin
          nxt_mode = rlp_pkg::RLP_RUN;
        end
      end
      rlp_pkg::RLP_PDOWN: begin
        nxt_mode = rlp_pkg::RLP_PDOWN;
      end
    endcase
    // Reset overrides every mode
    if (rst_hit) begin
      nxt_mode = rlp_pkg::RLP_RESET;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      mode_ff <= rlp_pkg::RLP_RESET;
    end else begin
      mode_ff <= nxt_mode;
    end
  end

  // Power control register: written in run, idle bit cleared on wake
  always_ff @(posedge clk) begin
    if (!nrst) begin
      power_control_register <= rlp_pkg::PWR_RESET;
    end else if (nxt_mode == rlp_pkg::RLP_RESET) begin
      power_control_register <= rlp_pkg::PWR_RESET;
    end else if (mode_ff == rlp_pkg::RLP_IDLE && nxt_mode == rlp_pkg::RLP_RUN) begin
      power_control_register[rlp_pkg::PWR_IDLE_BIT] <= 1'b0;
    end else if (pwr_wr && mode_ff == rlp_pkg::RLP_RUN) begin
      power_control_register <= pwr_wdata & rlp_pkg::PWR_WR_MASK;
    end
  end

  // Clock and retention enables per mode
  always_ff @(posedge clk) begin
    if (!nrst) begin
      core_reset <= 1'b1;
      core_run   <= 1'b0;
      periph_run <= 1'b0;
      osc_enable <= 1'b1;
      ram_retain <= 1'b0;
      sfr_retain <= 1'b0;
    end else begin
      core_reset <= nxt_mode == rlp_pkg::RLP_RESET;
      core_run   <= nxt_mode == rlp_pkg::RLP_RUN;
      periph_run <= nxt_mode inside {rlp_pkg::RLP_RUN, rlp_pkg::RLP_IDLE};
      osc_enable <= nxt_mode != rlp_pkg::RLP_PDOWN;
      ram_retain <= nxt_mode inside {rlp_pkg::RLP_IDLE, rlp_pkg::RLP_PDOWN};
      sfr_retain <= nxt_mode == rlp_pkg::RLP_IDLE;
    end
  end

  // Access select latched while in reset; ignored afterwards
  always_ff @(posedge clk) begin
    if (!nrst) begin
      locked_access_ff <= 1'b0;
    end else if (mode_ff == rlp_pkg::RLP_RESET) begin
      locked_access_ff <= access_s;
    end
  end

  // Pin states: idle strobes high, power-down low; port 0 floats in both on external memory
  always_ff @(posedge clk) begin
    if (!nrst) begin
      address_latch_strobe <= 1'b1;
      program_store_strobe <= 1'b1;
      port0_oe_block       <= 1'b0;
      port2_addr_sel       <= 1'b0;
      ext_mem_mode         <= 1'b0;
    end else begin
      ext_mem_mode <= locked_access_ff;
      unique case (nxt_mode)
        rlp_pkg::RLP_IDLE: begin
          address_latch_strobe <= 1'b1;
          program_store_strobe <= 1'b1;
          port0_oe_block       <= locked_access_ff;
          port2_addr_sel       <= locked_access_ff;
        end
        rlp_pkg::RLP_PDOWN: begin
          address_latch_strobe <= 1'b0;
          program_store_strobe <= 1'b0;
          port0_oe_block       <= locked_access_ff;
          port2_addr_sel       <= 1'b0;
        end
        rlp_pkg::RLP_RUN: begin
          address_latch_strobe <= ale_run;
          program_store_strobe <= prog_strobe_run;
          port0_oe_block       <= 1'b0;
          port2_addr_sel       <= locked_access_ff;
        end
        rlp_pkg::RLP_RESET: begin
          address_latch_strobe <= 1'b1;
          program_store_strobe <= 1'b1;
          port0_oe_block       <= 1'b0;
          port2_addr_sel       <= 1'b0;
        end
      endcase
    end
  end

  // Source is fixed by the latched select, so a mid-instruction switch cannot
  // reach internal code
  always_ff @(posedge clk) begin
    if (!nrst) begin
      code_read_grant  <= 1'b0;
      irom_read_en     <= 1'b0;
    end else begin
      code_read_grant  <= code_read_instr && !locked_access_ff && !test_mode
                          && !(security_bit && fetch_external);
      irom_read_en     <= !locked_access_ff && !test_mode && !fetch_external
                          && (fetch_internal || (code_read_instr && !security_bit));
    end
  end
endmodule // rlp_ctrl

//--- verilog/rlp_pkg.sv
// Purpose: Constants for the reset and low-power controller
// Assumes: One system clock; oscillator input sampled as a level
// Notes:   Power-control bits use the low nibble and bit 7 of the register
package rlp_pkg;
  // Reset stretch in oscillator periods (two machine cycles)
  localparam int unsigned RST_OSC_PERIODS = 24;
  // Divided ticks, two oscillator periods each, counted on the clock enable
  localparam int unsigned RST_HALF_TICKS  = RST_OSC_PERIODS / 2;
  localparam int unsigned RST_CNT_W       = 5;

  // Power control register field positions
  localparam int unsigned PWR_IDLE_BIT  = 0;
  localparam int unsigned PWR_DOWN_BIT  = 1;
  localparam int unsigned PWR_FLAG0_BIT = 2;
  localparam int unsigned PWR_FLAG1_BIT = 3;
  localparam int unsigned PWR_BAUD_BIT  = 7;
  localparam logic [7:0]  PWR_RESET     = 8'h00;
  localparam logic [7:0]  PWR_WR_MASK   = 8'h8f;
  // Sync reset levels {select, oscillator, reset pin}; reset pin starts asserted
  localparam logic [2:0]  PIN_SYNC_RST  = 3'h1;

  // Mode states
  typedef enum logic [1:0] {
    RLP_RESET,
    RLP_RUN,
    RLP_IDLE,
    RLP_PDOWN
  } rlp_mode_e;
endpackage

//--- verilog/rlp_sync.sv
// Purpose: Two-stage synchroniser for pin levels
// Assumes: Inputs are asynchronous to clk
// Notes:   First stage is read only by the second stage
`timescale 1ns/1ps
module rlp_sync #(
  parameter int unsigned  W       = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input  wire logic         clk,
  input  wire logic         nrst,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_ff;

  // Two flops, loaded with each pin's safe level by reset
  always_ff @(posedge clk) begin
    if (!nrst) begin
      meta_ff <= RST_VAL;
      q       <= RST_VAL;
    end else begin
      meta_ff <= d;
      q       <= meta_ff;
    end
  end
endmodule // rlp_sync

//--- tb/rlp_checker.sv
// Purpose: Port assertions for the reset and low-power controller
// Assumes: Sees top-level ports only
// Notes:   Entry windows allow two edges of slack
`timescale 1ns/1ps
module rlp_checker (
  input wire logic       clk,
  input wire logic       nrst,
  input wire logic       reset_pin,
  input wire logic       security_bit,
  input wire logic       instr_done,
  input wire logic       irq_pending,
  input wire logic       fetch_external,
  input wire logic       core_reset,
  input wire logic       core_run,
  input wire logic       periph_run,
  input wire logic       osc_enable,
  input wire logic       sfr_retain,
  input wire logic [7:0] power_control_register,
  input wire logic       address_latch_strobe,
  input wire logic       program_store_strobe,
  input wire logic       ext_mem_mode,
  input wire logic       irom_read_en
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  // Idle seen at the pins: peripherals on, core halted
  wire idle = periph_run && !core_run && !core_reset;
  wire [7:0] pc = power_control_register;
  sequence s_done; core_run && instr_done; endsequence
  sequence s_idle; !core_run && periph_run && sfr_retain; endsequence
  AST_IDLE_IN:
    assert property (s_done ##0 (pc[0] && !pc[1]) |-> ##[1:3] s_idle)
    else $error("idle entry missed");
  AST_PD_IN:
    assert property (s_done ##0 pc[1] |-> ##[1:3] !osc_enable)
    else $error("power-down entry missed");
  AST_PD_PINS:
    assert property (!osc_enable |-> !address_latch_strobe && !program_store_strobe && !sfr_retain)
    else $error("power-down pin state wrong");
  AST_IDLE_PINS:
    assert property (idle |-> address_latch_strobe && program_store_strobe && sfr_retain)
    else $error("idle pin state wrong");
  AST_WAKE:
    assert property (idle && irq_pending |-> ##[1:4] core_run)
    else $error("idle not ended by interrupt");
  AST_PD_HOLD:
    assert property (!osc_enable && !core_reset |=> !core_run)
    else $error("power-down left without reset");
  AST_RST_LEN:
    assert property ($rose(core_reset) |-> $past(reset_pin, 80))
    else $error("reset taken from short pin pulse");
  AST_ACCESS_LATCH:
    assert property (!core_reset && !$past(core_reset) |-> $stable(ext_mem_mode))
    else $error("access select changed after reset");
  AST_SEC:
    assert property (security_bit && fetch_external |=> !irom_read_en)
    else $error("protected code readable");
endmodule // rlp_checker

bind rlp_ctrl rlp_checker chk_u (.clk, .nrst, .reset_pin, .security_bit, .instr_done,
  .irq_pending, .fetch_external, .core_reset, .core_run, .periph_run, .osc_enable,
  .sfr_retain, .power_control_register, .address_latch_strobe, .program_store_strobe,
  .ext_mem_mode, .irom_read_en);

//--- tb/rlp_partner.sv
// Purpose: Reset circuit and oscillator model
// Assumes: Oscillator runs free with a 40 ns period
// Notes:   Bench loads left to request a pin pulse
`timescale 1ns/1ps
module rlp_partner (
  input  wire logic clk,
  output logic      oscillator_input,
  output logic      reset_pin
);
  int unsigned left = 200;
  initial oscillator_input = 1'b0;
  initial reset_pin = 1'b1;
  // Uneven duty on purpose, the divider must hide it
  always begin
    #30 oscillator_input = 1'b1;
    #10 oscillator_input = 1'b0;
  end
  // Pin high while the hold count runs
  always @(posedge clk) reset_pin <= (left != 0);
  // Far edge, so a bench load on the rising edge never races
  always @(negedge clk) if (left != 0) left--;
endmodule // rlp_partner

//--- tb/testbench.sv
// Purpose: Self-checking bench for the reset and low-power controller
// Assumes: 12 ticks take 96 clk cycles
// Notes:   Run strobes low for idle, high for power-down, so pin levels stand out
`timescale 1ns/1ps
module testbench;
  logic clk = 1'b0, nrst = 1'b0, external_access_select = 1'b0, security_bit = 1'b0;
  logic pwr_wr = 1'b0, instr_done = 1'b0, irq_pending = 1'b0, code_read_instr = 1'b0;
  logic ale_run = 1'b0, prog_strobe_run = 1'b0, osc_tick;
  logic fetch_internal = 1'b1, fetch_external = 1'b0, test_mode = 1'b0;
  logic [7:0] pwr_wdata = 8'h00, power_control_register;
  logic oscillator_input, reset_pin, core_reset, core_run, periph_run, osc_enable;
  logic ram_retain, sfr_retain, address_latch_strobe, program_store_strobe;
  logic port0_oe_block, port2_addr_sel, ext_mem_mode, code_read_grant, irom_read_en;
  int err_total = 0, checked = 0, cyc = 0;
  rlp_ctrl dut_u (.clk, .nrst, .oscillator_input, .reset_pin, .external_access_select,
    .security_bit, .pwr_wr, .pwr_wdata, .instr_done, .irq_pending, .ale_run,
    .prog_strobe_run, .code_read_instr, .fetch_internal, .fetch_external, .test_mode,
    .osc_tick, .core_reset, .core_run, .periph_run, .osc_enable, .ram_retain, .sfr_retain,
    .power_control_register, .address_latch_strobe, .program_store_strobe,
    .port0_oe_block, .port2_addr_sel, .ext_mem_mode, .code_read_grant, .irom_read_en);
  rlp_partner prt_u (.clk, .oscillator_input, .reset_pin);
  always #5 clk = ~clk;
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // Hang guard, well above the expected run
  always @(posedge clk) begin
    cyc++;
    if (cyc == 4000) begin
      err_total++;
      print_verdict;
    end
  end
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    checked++;
    if (g !== e) begin
      err_total++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // Sample after the edge's updates have landed
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wait_run(input int n);
    for (int i = 0; i < n && core_run !== 1'b1; i++) tick(1);
  endtask
  // Pin pulse of n cycles, then wait for the core to run again
  task automatic pin_reset(input int n);
    @(posedge clk);
    prt_u.left <= n;
    tick(n - 5);
    chk(core_reset, 1);
    wait_run(60);
  endtask
  task automatic enter(input logic [7:0] d);
    @(posedge clk);
    pwr_wr <= 1'b1;
    pwr_wdata <= d;
    @(posedge clk);
    pwr_wr <= 1'b0;
    instr_done <= 1'b1;
    @(posedge clk);
    instr_done <= 1'b0;
    tick(3);
  endtask
  task automatic t_reset;
    wait_run(600);
    chk(core_run, 1);
    chk(power_control_register, rlp_pkg::PWR_RESET);
    @(posedge clk);
    external_access_select <= 1'b1;
    tick(5);
    chk(ext_mem_mode, 0);
    $display("test reset done");
  endtask
  task automatic t_code;
    @(posedge clk);
    code_read_instr <= 1'b1;
    tick(2);
    chk(code_read_grant, 1);
    @(posedge clk);
    security_bit <= 1'b1;
    fetch_internal <= 1'b0;
    fetch_external <= 1'b1;
    tick(2);
    chk({code_read_grant, irom_read_en}, 0);
    @(posedge clk);
    fetch_internal <= 1'b1;
    fetch_external <= 1'b0;
    test_mode <= 1'b1;
    tick(2);
    chk(irom_read_en, 0);
    @(posedge clk);
    {code_read_instr, test_mode, security_bit} <= 3'h0;
    tick(2);
    chk(code_read_grant, 0);
    chk(irom_read_en, 1);
    $display("test code done");
  endtask
  task automatic t_idle;
    enter(8'h01);
    chk({core_run, periph_run, sfr_retain}, 3);
    chk({address_latch_strobe, program_store_strobe}, 3);
    chk({port0_oe_block, port2_addr_sel}, 0);
    @(posedge clk);
    irq_pending <= 1'b1;
    wait_run(8);
    chk({core_run, power_control_register}, 9'h100);
    @(posedge clk);
    irq_pending <= 1'b0;
    enter(8'h01);
    pin_reset(130);
    chk({ext_mem_mode, power_control_register}, 9'h100);
    $display("test idle done");
  endtask
  task automatic t_pd;
    enter(8'h01);
    chk({port0_oe_block, port2_addr_sel}, 3);
    @(posedge clk);
    irq_pending <= 1'b1;
    wait_run(8);
    chk(core_run, 1);
    @(posedge clk);
    irq_pending <= 1'b0;
    ale_run <= 1'b1;
    prog_strobe_run <= 1'b1;
    enter(8'hf3);
    chk(power_control_register, 8'h83);
    chk({osc_enable, ram_retain, sfr_retain}, 2);
    chk({address_latch_strobe, program_store_strobe}, 0);
    chk({port0_oe_block, port2_addr_sel}, 2);
    @(posedge clk);
    irq_pending <= 1'b1;
    tick(20);
    chk(core_run, 0);
    @(posedge clk);
    irq_pending <= 1'b0;
    pin_reset(130);
    chk({core_run, osc_enable}, 3);
    $display("test power-down done");
  endtask
  task automatic t_pin;
    @(posedge clk);
    prt_u.left <= 60;
    tick(80);
    chk(core_run, 1);
    pin_reset(110);
    chk(core_run, 1);
    $display("test pin done");
  endtask
  // Any 80-cycle window holds exactly ten divided ticks
  task automatic t_div;
    logic [15:0] n;
    n = 16'h0000;
    repeat (80) begin
      tick(1);
      n = n + 16'(osc_tick);
    end
    chk(n, 10);
    $display("test divider done");
  endtask
  initial begin
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    t_reset;
    t_div;
    t_code;
    t_idle;
    t_pd;
    t_pin;
    print_verdict;
  end
endmodule // testbench
